// >>> iod_pkg.sv
// Functional notes
// RULE1 - With the extension on, an access-bank operand up to 5Fh is an offset from the stack frame pointer, not an absolute address.
// RULE2 - Pattern 0010 01d0 kkkk kkkk adds the accumulator to the byte at pointer plus k and routes the sum to the chosen destination.
// RULE3 - For the indexed add, destination bit 0 writes the accumulator and 1 (the default) writes the data byte.
// RULE4 - The indexed add updates negative, overflow, carry, digit-carry and zero from the sum.
// RULE5 - Each indexed instruction is one word and one instruction cycle: decode, offset read, process, write. The fill issues no operand read strobe in the code.
// RULE6 - Pattern 1000 bbb0 kkkk kkkk sets bit b (0 to 7) of the byte at pointer plus k, flags untouched.
// RULE7 - Pattern 0110 1000 kkkk kkkk writes FFh to the byte at pointer plus k (offset 0 to 95), flags untouched.
// RULE8 - Extension and indexed addressing stay off while the enable configuration bit is 0.
// RULE9 - Reinterpretation applies only when the access bit is 0; with 1 the bank select register picks the bank.
// RULE10 - With the extension off, operands are absolute addresses in the access bank or selected bank.
// RULE11 - Effective address is the unsigned sum of pointer and zero-extended offset; the pointer is not modified.
package iod_pkg;
    localparam int ADDR_W = 12;
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [5:0] OPC_ADD_HI = 6'h09;
    localparam logic [3:0] OPC_BSET_HI = 4'h8;
    localparam logic [7:0] OPC_FILL_HI = 8'h68;
    localparam int BIT_ACCESS = 8;
    localparam int BIT_DEST = 9;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [3:0] PHASE_RST = 4'h1;
    typedef enum logic [3:0] {
        IOD_Q1 = 4'b0001,
        IOD_Q2 = 4'b0010,
        IOD_Q3 = 4'b0100,
        IOD_Q4 = 4'b1000
    } iod_phase_e;
endpackage

// >>> iod_ea_gen.sv
`timescale 1ns/1ps
// ****************************************************************
// Effective address former
// ****************************************************************
module iod_ea_gen #(
    parameter int AW = 12
) (
    // Operand sources
    input wire logic [AW-1:0] i_frame_ptr,
    input wire logic [7:0] i_operand,
    input wire logic [3:0] i_bank_sel,
    input wire logic i_access_bit,
    input wire logic i_ext_en,
    // Result
    output logic [AW-1:0] o_addr,
    output logic o_indexed
);
    if (AW != 12) begin : g_bad_width
        $error("iod_ea_gen serves an address width of twelve only");
    end
    always_comb begin
        o_indexed = i_ext_en && !i_access_bit
                    && (i_operand <= iod_pkg::OFFSET_LIMIT); // RULE1 RULE8 RULE9
        if (o_indexed) begin
            o_addr = i_frame_ptr + {4'h0, i_operand}; // RULE11
        end else if (i_access_bit) begin
            o_addr = {i_bank_sel, i_operand}; // RULE9 RULE10
        end else if (i_operand < iod_pkg::ACCESS_SPLIT) begin
            o_addr = {4'h0, i_operand}; // RULE10
        end else begin
            o_addr = {iod_pkg::ACCESS_HIGH_BANK, i_operand}; // RULE10
        end
    end
endmodule

// >>> iod_core.sv
`timescale 1ns/1ps
module iod_core (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Configuration and core context
    input wire logic i_ext_set_en,
    input wire logic [15:0] i_opcode,
    input wire logic i_opcode_valid,
    input wire logic [11:0] i_stack_frame_pointer,
    input wire logic [3:0] i_bank_select_register,
    // Data memory read data
    input wire logic [7:0] i_mem_rdata,
    // Data memory port
    output logic [11:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [7:0] o_mem_wdata,
    // Core state
    output logic [7:0] o_accum,
    output logic [4:0] o_flags,
    output logic o_indexed,
    output logic o_done,
    output logic [3:0] o_phase
);
    // ****************************************************************
    // State
    // ****************************************************************
    // Operation latched at decode
    typedef enum logic [1:0] {
        IOD_OP_NONE = 2'h0,
        IOD_OP_ADD = 2'h1,
        IOD_OP_BSET = 2'h2,
        IOD_OP_FILL = 2'h3
    } iod_op_e;
    // Whole module state as one record
    typedef struct packed {
        iod_pkg::iod_phase_e phase;
        iod_op_e op;
        logic dest_file;
        logic [2:0] bitno;
        logic [11:0] addr;
        logic indexed;
        logic [7:0] data;
        logic [7:0] accum;
        logic [4:0] flags;
        logic mem_rd;
        logic mem_wr;
        logic done;
    } iod_state_s;
    // ****************************************************************
    // Signals
    // ****************************************************************
    iod_state_s st_q;
    iod_state_s st_d;
    logic [11:0] ea;
    logic ea_indexed;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opnd;
    logic [7:0] bit_mask;
    logic dec_add;
    logic dec_bset;
    logic dec_fill;
    logic add_c;
    logic add_dc;
    logic add_z;
    logic add_n;
    logic add_ov;
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Address ports are fixed at twelve bits
    if (iod_pkg::ADDR_W != 12) begin : g_bad_width
        $error("iod_core serves a twelve bit address only");
    end
    // ****************************************************************
    // Address forming
    // ****************************************************************
    iod_ea_gen #(.AW(iod_pkg::ADDR_W)) u_ea (
        .i_frame_ptr(i_stack_frame_pointer),
        .i_operand(i_opcode[7:0]),
        .i_bank_sel(i_bank_select_register),
        .i_access_bit(i_opcode[iod_pkg::BIT_ACCESS]),
        .i_ext_en(i_ext_set_en),
        .o_addr(ea),
        .o_indexed(ea_indexed)
    );
    // ****************************************************************
    // Opcode decode
    // ****************************************************************
    // Upper fields only, so add and bit set decode with either access bit value; fill needs access bit 0
    assign dec_add = i_opcode[15:10] == iod_pkg::OPC_ADD_HI; // RULE2
    assign dec_bset = i_opcode[15:12] == iod_pkg::OPC_BSET_HI; // RULE6
    assign dec_fill = i_opcode[15:8] == iod_pkg::OPC_FILL_HI; // RULE7
    // ****************************************************************
    // Operand and arithmetic
    // ****************************************************************
    // Read data is used in the quarter it arrives, not a cycle late
    assign opnd = st_q.mem_rd ? i_mem_rdata : st_q.data;
    // Nine bits keep the carry out
    assign sum = {1'b0, st_q.accum} + {1'b0, opnd};
    assign nib = {1'b0, st_q.accum[3:0]} + {1'b0, opnd[3:0]};
    assign bit_mask = 8'h01 << st_q.bitno; // RULE6
    // ****************************************************************
    // Status results of the add
    // ****************************************************************
    assign add_c = sum[8]; // RULE4
    assign add_dc = nib[4]; // RULE4
    assign add_z = sum[7:0] == 8'h00; // RULE4
    assign add_n = sum[7]; // RULE4
    // Overflow: like signs in, the other sign out
    assign add_ov = (st_q.accum[7] == opnd[7])
        && (sum[7] != st_q.accum[7]); // RULE4
    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.mem_rd = 1'b0;
        st_d.mem_wr = 1'b0;
        st_d.done = 1'b0;
        case (st_q.phase)
            // Decode and latch the operand address
            iod_pkg::IOD_Q1: begin
                st_d.op = IOD_OP_NONE;
                if (i_opcode_valid) begin
                    if (dec_add) begin
                        st_d.op = IOD_OP_ADD; // RULE2
                    end else if (dec_bset) begin
                        st_d.op = IOD_OP_BSET; // RULE6
                    end else if (dec_fill) begin
                        st_d.op = IOD_OP_FILL; // RULE7
                    end
                end
                // Latched every slot; unused unless an op was taken
                st_d.dest_file = i_opcode[iod_pkg::BIT_DEST]; // RULE3
                st_d.bitno = i_opcode[11:9];
                st_d.addr = ea;
                st_d.indexed = ea_indexed;
                st_d.phase = iod_pkg::IOD_Q2;
            end
            // Operand read strobe
            iod_pkg::IOD_Q2: begin
                st_d.mem_rd = (st_q.op == IOD_OP_ADD)
                              || (st_q.op == IOD_OP_BSET); // RULE5
                st_d.phase = iod_pkg::IOD_Q3;
            end
            // Process the operand taken from the read
            iod_pkg::IOD_Q3: begin
                case (st_q.op)
                    IOD_OP_ADD: begin
                        st_d.data = sum[7:0]; // RULE2
                        st_d.flags[iod_pkg::FLAG_C] = add_c; // RULE4
                        st_d.flags[iod_pkg::FLAG_DC] = add_dc; // RULE4
                        st_d.flags[iod_pkg::FLAG_Z] = add_z; // RULE4
                        st_d.flags[iod_pkg::FLAG_N] = add_n; // RULE4
                        st_d.flags[iod_pkg::FLAG_OV] = add_ov; // RULE4
                    end
                    IOD_OP_BSET: begin
                        st_d.data = opnd | bit_mask; // RULE6
                    end
                    IOD_OP_FILL: begin
                        st_d.data = iod_pkg::ALL_ONES; // RULE7
                    end
                    default: begin
                        st_d.data = st_q.data;
                    end
                endcase
                st_d.phase = iod_pkg::IOD_Q4;
            end
            // Write to the destination
            iod_pkg::IOD_Q4: begin
                if (st_q.op == IOD_OP_ADD && !st_q.dest_file) begin
                    st_d.accum = st_q.data; // RULE3
                end else if (st_q.op != IOD_OP_NONE) begin
                    st_d.mem_wr = 1'b1; // RULE3 RULE5
                end
                st_d.done = (st_q.op != IOD_OP_NONE); // RULE5
                st_d.phase = iod_pkg::IOD_Q1;
            end
            // Not reachable with one-hot codes; recover to decode
            default: begin
                st_d.phase = iod_pkg::IOD_Q1;
            end
        endcase
    end
    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '{
                phase: iod_pkg::IOD_Q1,
                op: IOD_OP_NONE,
                dest_file: 1'b1,
                bitno: 3'h0,
                addr: 12'h000,
                indexed: 1'b0,
                data: 8'h00,
                accum: iod_pkg::ACCUM_RST,
                flags: iod_pkg::FLAGS_RST,
                mem_rd: 1'b0,
                mem_wr: 1'b0,
                done: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end
    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output is a field of the state register
    assign o_mem_addr = st_q.addr;
    assign o_mem_rd = st_q.mem_rd;
    assign o_mem_wr = st_q.mem_wr;
    assign o_mem_wdata = st_q.data;
    assign o_accum = st_q.accum;
    assign o_flags = st_q.flags;
    assign o_indexed = st_q.indexed;
    assign o_done = st_q.done;
    assign o_phase = st_q.phase;
endmodule

// >>> iod_core_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder timing and addressing checker
// ****************************************************************
module iod_core_assertions (
    // Clock, reset and core context
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ext_set_en,
    input wire logic i_opcode_valid,
    input wire logic [15:0] i_opcode,
    input wire logic [11:0] i_stack_frame_pointer,
    input wire logic [3:0] i_bank_select_register,
    // Observed outputs
    input wire logic o_mem_rd,
    input wire logic o_mem_wr,
    input wire logic o_indexed,
    input wire logic o_done,
    input wire logic [11:0] o_mem_addr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [4:0] o_flags,
    input wire logic [3:0] o_phase
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    logic take, fill, known;
    logic [11:0] ea_q, abs_q;
    assign take = o_phase == 4'h1 && i_opcode_valid;
    assign fill = i_opcode[15:8] == 8'h68;
    assign known = fill || i_opcode[15:12] == 4'h8
        || i_opcode[15:10] == 6'h09;
    // Expected addresses of the word taken at this edge
    always_ff @(posedge i_clk_sys) begin
        ea_q <= i_stack_frame_pointer + {4'h0, i_opcode[7:0]};
        abs_q <= {i_opcode[8] ? i_bank_select_register : 4'h0,
            i_opcode[7:0]};
    end
    a_phase_step: assert property (
        o_phase != 4'h8 |=> o_phase == $past(o_phase) << 1)
        else $error("phase did not advance");
    a_read_q3: assert property (o_mem_rd |-> o_phase == 4'h4)
        else $error("read strobe outside third quarter");
    a_write_done: assert property (
        o_mem_wr |-> o_done && o_phase == 4'h1)
        else $error("write strobe without completion");
    a_fill_ones: assert property (
        take && fill |-> ##4 o_mem_wr && o_done && o_mem_wdata == 8'hFF)
        else $error("fill did not write all ones");
    a_flags_kept: assert property (
        take && (fill || i_opcode[15:12] == 4'h8)
        |-> ##2 $stable(o_flags) [*3])
        else $error("flags moved on a bit or fill operation");
    a_add_dest: assert property (
        take && i_opcode[15:10] == 6'h09 |-> if (i_opcode[9])
        ##4 (o_mem_wr && o_done) else ##4 (o_done && !o_mem_wr))
        else $error("add result sent to wrong destination");
    a_index_addr: assert property (
        take && known && i_ext_set_en && !i_opcode[8]
        && i_opcode[7:0] <= 8'h5F |=> o_mem_addr == ea_q && o_indexed)
        else $error("indexed address wrong");
    a_plain_addr: assert property (
        take && known && (i_opcode[8] || !i_ext_set_en
        && i_opcode[7:0] <= 8'h5F) |=> o_mem_addr == abs_q && !o_indexed)
        else $error("absolute address wrong");
    a_fill_noread: assert property (
        take && fill |-> ##2 !o_mem_rd)
        else $error("fill issued an operand read");
    a_operand_read: assert property (
        take && known && !fill |-> ##2 o_mem_rd)
        else $error("operand read strobe missing");
endmodule

// >>> iod_core_test.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder testbench
// ****************************************************************
module iod_core_test;
    logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_ext_set_en = 1'b1;
    logic i_opcode_valid = 1'b0;
    logic [15:0] i_opcode = 16'h0000;
    logic [11:0] i_stack_frame_pointer = 12'hA00;
    logic [3:0] i_bank_select_register = 4'h3;
    logic [7:0] i_mem_rdata = 8'h00;
    logic o_mem_rd, o_mem_wr, o_indexed, o_done;
    logic [11:0] o_mem_addr;
    logic [7:0] o_mem_wdata, o_accum;
    logic [4:0] o_flags;
    logic [3:0] o_phase;
    int num_errors = 0;
    int n_tests = 0;
    logic rd_seen = 1'b0;
    iod_core u_iod_core (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ext_set_en(i_ext_set_en),
        .i_opcode(i_opcode),
        .i_opcode_valid(i_opcode_valid),
        .i_stack_frame_pointer(i_stack_frame_pointer),
        .i_bank_select_register(i_bank_select_register),
        .i_mem_rdata(i_mem_rdata),
        .o_mem_addr(o_mem_addr),
        .o_mem_rd(o_mem_rd),
        .o_mem_wr(o_mem_wr),
        .o_mem_wdata(o_mem_wdata),
        .o_accum(o_accum),
        .o_flags(o_flags),
        .o_indexed(o_indexed),
        .o_done(o_done),
        .o_phase(o_phase)
    );
    always #50 i_clk_sys = ~i_clk_sys;
    task results;
        $display("mismatches %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h",
                $time, seen, exp);
        end
    endtask
    // Waits for the opcode slot, issues one word, returns in the next Q1 after its write
    task run(input logic [15:0] op, input logic [7:0] rd);
        for (int i = 0; i < 8 && o_phase !== 4'h1; i++) begin
            @(posedge i_clk_sys) #1;
        end
        if (o_phase !== 4'h1) begin
            num_errors++;
            results;
        end
        i_opcode = op;
        i_mem_rdata = rd;
        i_opcode_valid = 1'b1;
        @(posedge i_clk_sys) #1;
        i_opcode_valid = 1'b0;
        @(posedge i_clk_sys) #1;
        rd_seen = o_mem_rd;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask
    task t_add;
        run(16'h242C, 8'h20);
        check(o_mem_addr, 12'hA2C);
        check(o_indexed, 1'b1);
        check(rd_seen, 1'b1);
        check(o_mem_wr, 1'b0);
        check(o_accum, 8'h20);
        check(o_phase, 4'h1);
        run(16'h262C, 8'hE0);
        check(o_mem_wdata, 8'h00);
        check(o_mem_wr, 1'b1);
        check(o_done, 1'b1);
        check(o_accum, 8'h20);
        check(o_flags, 5'h05);
        run(16'h242C, 8'h68);
        check(o_flags, 5'h18);
        run(16'h242C, 8'h0F);
        check(o_flags, 5'h12);
        run(16'h0000, 8'h00);
        check(o_done, 1'b0);
        check(o_accum, 8'h97);
    endtask
    task t_bits;
        for (int b = 0; b < 8; b++) begin
            run({4'h8, 3'(b), 9'h00A}, 8'h55);
            check(o_mem_wdata, 8'h55 | (8'h01 << b));
            check(o_mem_addr, 12'hA0A);
            check(o_flags, 5'h12);
        end
    endtask
    task t_fill;
        run(16'h685F, 8'h00);
        check(o_mem_addr, 12'hA5F);
        check(o_mem_wdata, 8'hFF);
        check(rd_seen, 1'b0);
        check(o_done, 1'b1);
        run(16'h6860, 8'h00);
        check(o_mem_addr, 12'hF60);
        run(16'h810A, 8'h00);
        check(o_mem_addr, 12'h30A);
        check(o_indexed, 1'b0);
        check(o_mem_wdata, 8'h01);
    endtask
    task t_off;
        i_ext_set_en = 1'b0;
        run(16'h682C, 8'h00);
        check(o_mem_addr, 12'h02C);
        check(o_indexed, 1'b0);
        i_ext_set_en = 1'b1;
    endtask
    // Reset in the middle of an add, then a clean add from zero
    task t_reset;
        i_opcode = 16'h242C;
        i_opcode_valid = 1'b1;
        @(posedge i_clk_sys) #1;
        i_opcode_valid = 1'b0;
        @(posedge i_clk_sys) #1;
        i_rst_b = 1'b0;
        #1;
        check(o_phase, 4'h1);
        check(o_accum, 8'h00);
        check(o_flags, 5'h00);
        check(o_mem_rd, 1'b0);
        @(posedge i_clk_sys) #1;
        i_rst_b = 1'b1;
        run(16'h242C, 8'h11);
        check(o_accum, 8'h11);
    endtask
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rst_b = 1'b1;
        t_add;
        t_bits;
        t_fill;
        t_off;
        t_reset;
        results;
    end
endmodule
bind iod_core iod_core_assertions u_iod_core_assertions (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ext_set_en(i_ext_set_en),
    .i_opcode_valid(i_opcode_valid),
    .i_opcode(i_opcode),
    .i_stack_frame_pointer(i_stack_frame_pointer),
    .i_bank_select_register(i_bank_select_register),
    .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr),
    .o_indexed(o_indexed),
    .o_done(o_done),
    .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .o_flags(o_flags),
    .o_phase(o_phase)
);
